// ### usb_host_list_engine.v
// Contract
// - Operational controls enter only through dedicated ports
// - Master reads fetch endpoint and transfer descriptors
// - Payload words move directly through master port
// - Write completion status, retire descriptor from queue
// - Abort or misalignment sets sticky unrecoverable error
// - Root hub port count is read-only output
// - Port logic detects attach without software polling
// - Transceiver lines driven only by root ports
// - Software enables over-current protection via controller
// - Register side and USB side clocking; here one clock_i serves both
// - Target for controls, master for shared area
// - Holds pointer to shared communication area
// - Endpoint four dwords, transfer four dwords
// - Walk transfer queue hanging from each endpoint
// - Control layout follows the open host interface
// - Supports low and full speed devices
`timescale 1ns/1ps
`default_nettype none
`include "usb_host_regs.vh"
module usb_host_list_engine #(
  parameter NUM_PORTS = `ROOT_PORTS,
  parameter DEB_CYCLES = `ATTACH_DEBOUNCE_CYCLES
) (
  input  wire                 clock_i,
  input  wire                 rst_b_i,
  input  wire                 list_enable_i,
  input  wire [31:0]          hcca_base_i,
  input  wire [31:0]          list_head_i,
  input  wire                 error_clear_i,
  output reg                  unrecoverable_error_o,
  output wire [7:0]           num_ports_o,
  output reg  [31:0]          done_head_o,
  output wire                 mem_req_o,
  output reg                  mem_we_o,
  output reg  [31:0]          mem_addr_o,
  output reg  [31:0]          mem_wdata_o,
  input  wire                 mem_ack_i,
  input  wire                 mem_err_i,
  input  wire [31:0]          mem_rdata_i,
  output reg  [31:0]          tx_data_o,
  output reg                  tx_valid_o,
  input  wire                 tx_ready_i,
  input  wire [31:0]          rx_data_i,
  input  wire                 rx_valid_i,
  output wire                 rx_ready_o,
  input  wire [2:0]           desc_rd_addr_i,
  output wire [31:0]          desc_rd_data_o,
  input  wire [NUM_PORTS-1:0] host_data_plus_line_i,
  input  wire [NUM_PORTS-1:0] host_data_minus_line_i,
  output wire [NUM_PORTS-1:0] host_data_plus_line_o,
  output wire [NUM_PORTS-1:0] host_data_minus_line_o,
  output wire [NUM_PORTS-1:0] host_data_line_oe_o,
  input  wire [NUM_PORTS-1:0] port_reset_i,
  input  wire [NUM_PORTS-1:0] port_power_en_i,
  input  wire                 overcurrent_protect_en_i,
  output wire [NUM_PORTS-1:0] port_power_o,
  output reg  [NUM_PORTS-1:0] port_connect_o,
  output reg  [NUM_PORTS-1:0] port_low_speed_o,
  output reg  [NUM_PORTS-1:0] port_connect_change_o
);
  // Walker states
  localparam S_IDLE   = 4'h0;
  localparam S_ED_RD  = 4'h1;
  localparam S_TD_RD  = 4'h2;
  localparam S_DATA   = 4'h3;
  localparam S_TD_WB0 = 4'h4;
  localparam S_TD_WB1 = 4'h5;
  localparam S_TD_WB2 = 4'h6;
  localparam S_ED_WB  = 4'h7;
  localparam S_HC_WB  = 4'h8;
  localparam S_HALT   = 4'h9;

  reg  [3:0]  state;       // Walker state
  reg  [2:0]  wcnt;        // Dword index inside a descriptor
  reg         busy;        // Access outstanding on master port
  reg  [31:0] ed_ptr;      // Current endpoint descriptor
  reg  [31:0] td_ptr;      // Current transfer descriptor
  reg  [31:0] ed_ctrl;     // Endpoint control dword
  reg  [31:0] ed_tail;     // Queue tail pointer
  reg  [31:0] ed_head;     // Queue head pointer with flags
  reg  [31:0] td_ctrl;     // Transfer control dword
  reg  [31:0] td_cbp;      // Current buffer pointer
  reg  [31:0] td_next;     // Next transfer in queue
  reg  [31:0] td_be;       // Buffer end, last byte
  reg  [31:0] cur_addr;    // Address the state wants
  reg  [31:0] cur_wdata;   // Write data the state wants
  reg         cur_we;      // Direction the state wants
  reg         cur_bad;     // Address violates alignment
  reg         cur_go;      // Access may start now
  wire        is_mem;      // State uses master port
  wire        dir_in;      // Transfer moves data into memory
  wire        done;        // Access completed without fault
  wire        fault;       // Abort or alignment fault

  assign num_ports_o = NUM_PORTS[7:0];
  assign is_mem = (state != S_IDLE) && (state != S_HALT);
  assign dir_in = (td_ctrl[`TD_DP_HI:`TD_DP_LO] == `TD_DP_IN);
  assign mem_req_o = busy;
  assign done = busy && mem_ack_i && !mem_err_i;
  assign fault = (busy && mem_err_i) || (is_mem && !busy && cur_go && cur_bad);
  // Incoming word is consumed on the cycle its write is acknowledged
  assign rx_ready_o = done && (state == S_DATA) && dir_in;

  // Address, data and alignment check for each walker state
  always @* begin
    cur_addr = 32'h0000_0000;
    cur_wdata = 32'h0000_0000;
    cur_we = 1'b0;
    cur_go = 1'b1;
    cur_bad = 1'b0;
    case (state)
      S_ED_RD: begin
        cur_addr = ed_ptr + {27'h0, wcnt, 2'h0};
        cur_bad = |(ed_ptr & `DESC_ALIGN_MASK);
      end
      S_TD_RD: begin
        cur_addr = td_ptr + {27'h0, wcnt, 2'h0};
        cur_bad = |(td_ptr & `DESC_ALIGN_MASK);
      end
      S_DATA: begin
        cur_addr = td_cbp;
        cur_we = dir_in;
        cur_wdata = rx_data_i;
        cur_bad = |(td_cbp & `WORD_ALIGN_MASK);
        // Stall until the serial side has room or a word
        cur_go = dir_in ? rx_valid_i : !tx_valid_o;
      end
      S_TD_WB0: begin
        cur_addr = td_ptr + `TD_CTRL_OFS;
        cur_wdata = {`TD_CC_NOERROR, td_ctrl[27:0]};
        cur_we = 1'b1;
      end
      S_TD_WB1: begin // Buffer fully consumed
        cur_addr = td_ptr + `TD_CBP_OFS;
        cur_we = 1'b1;
      end
      S_TD_WB2: begin // Link onto done queue
        cur_addr = td_ptr + `TD_NEXT_OFS;
        cur_wdata = done_head_o;
        cur_we = 1'b1;
      end
      S_ED_WB: begin // Retire: head moves to next transfer
        cur_addr = ed_ptr + `ED_HEAD_OFS;
        cur_wdata = {td_next[31:4], ed_head[3:0]};
        cur_we = 1'b1;
      end
      S_HC_WB: begin // Done head into shared area
        cur_addr = hcca_base_i + `HCCA_DONE_OFS;
        cur_wdata = td_ptr;
        cur_we = 1'b1;
        cur_bad = |(hcca_base_i & `HCCA_ALIGN_MASK);
      end
      default: begin
        cur_go = 1'b0;
      end
    endcase
  end

  // List walker and master port sequencing
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      wcnt <= 3'h0;
      busy <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
      ed_ptr <= 32'h0000_0000;
      td_ptr <= 32'h0000_0000;
      ed_ctrl <= 32'h0000_0000;
      ed_tail <= 32'h0000_0000;
      ed_head <= 32'h0000_0000;
      td_ctrl <= 32'h0000_0000;
      td_cbp <= 32'h0000_0000;
      td_next <= 32'h0000_0000;
      td_be <= 32'h0000_0000;
      done_head_o <= 32'h0000_0000;
      unrecoverable_error_o <= 1'b0;
      tx_data_o <= 32'h0000_0000;
      tx_valid_o <= 1'b0;
    end else begin
      // Serial side drains outgoing word
      if (tx_valid_o && tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
      // Fault sets error; set wins over software clear
      if (fault) begin
        unrecoverable_error_o <= 1'b1;
      end else if (error_clear_i) begin
        unrecoverable_error_o <= 1'b0;
      end
      if (fault) begin
        busy <= 1'b0;
        state <= S_HALT;
      end else if (is_mem && !busy && cur_go) begin
        busy <= 1'b1;
        mem_addr_o <= cur_addr;
        mem_wdata_o <= cur_wdata;
        mem_we_o <= cur_we;
      end else if (done) begin
        busy <= 1'b0;
        case (state)
          S_ED_RD: begin
            wcnt <= wcnt + 3'h1;
            if (wcnt == 3'h0) begin
              ed_ctrl <= mem_rdata_i;
            end else if (wcnt == 3'h1) begin
              ed_tail <= mem_rdata_i;
            end else if (wcnt == 3'h2) begin
              ed_head <= mem_rdata_i;
            end else begin
              wcnt <= 3'h0;
              // Empty, skipped or halted endpoint moves on
              if (ed_ctrl[`ED_SKIP_BIT] || ed_head[`ED_HALT_BIT] ||
                  (ed_head[31:4] == ed_tail[31:4])) begin
                ed_ptr <= mem_rdata_i;
                state <= (mem_rdata_i == 32'h0000_0000) ? S_IDLE : S_ED_RD;
              end else begin
                td_next <= mem_rdata_i; // Parked next endpoint
                td_ptr <= {ed_head[31:4], 4'h0};
                state <= S_TD_RD;
              end
            end
          end
          S_TD_RD: begin
            wcnt <= wcnt + 3'h1;
            if (wcnt == 3'h0) begin
              td_ctrl <= mem_rdata_i;
            end else if (wcnt == 3'h1) begin
              td_cbp <= mem_rdata_i;
            end else if (wcnt == 3'h2) begin
              td_next <= mem_rdata_i;
            end else begin
              wcnt <= 3'h0;
              td_be <= mem_rdata_i;
              state <= (td_cbp == 32'h0000_0000) ? S_TD_WB0 : S_DATA;
            end
          end
          S_DATA: begin
            if (!dir_in) begin
              tx_data_o <= mem_rdata_i;
              tx_valid_o <= 1'b1;
            end
            td_cbp <= td_cbp + 32'h0000_0004;
            if (td_cbp[31:2] == td_be[31:2]) begin
              state <= S_TD_WB0;
            end
          end
          S_TD_WB0: state <= S_TD_WB1;
          S_TD_WB1: state <= S_TD_WB2;
          S_TD_WB2: state <= S_ED_WB;
          S_ED_WB:  state <= S_HC_WB;
          S_HC_WB: begin
            done_head_o <= td_ptr;
            // Revisit same endpoint for its next queued transfer
            state <= S_ED_RD;
          end
          default: state <= S_IDLE;
        endcase
      end else if (state == S_IDLE) begin
        if (list_enable_i && (list_head_i != 32'h0000_0000)) begin
          ed_ptr <= list_head_i;
          wcnt <= 3'h0;
          state <= S_ED_RD;
        end
      end else if (state == S_HALT) begin
        // Leave halt only once software has cleared the error
        if (!unrecoverable_error_o && !list_enable_i) begin
          state <= S_IDLE;
        end
      end
    end
  end

  // Raw copy of fetched descriptors for inspection
  desc_buffer #(
    .AW (3),
    .DW (32)
  ) u_desc_buffer (
    .clock_i   (clock_i),
    .wr_en_i   (done && ((state == S_ED_RD) || (state == S_TD_RD))),
    .wr_addr_i ({(state == S_TD_RD), wcnt[1:0]}),
    .wr_data_i (mem_rdata_i),
    .rd_addr_i (desc_rd_addr_i),
    .rd_data_o (desc_rd_data_o)
  );

  // Per-port line synchronisers, attach detect and drive
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      reg [1:0]  dp_sync;   // Two-stage sync of plus line into the one clock
      reg [1:0]  dm_sync;   // Two-stage sync of minus line
      reg [15:0] deb;       // Stable-line counter
      reg        line_prev; // Last sampled attach level
      wire       attached;  // Pull-up seen on either line
      assign attached = dp_sync[1] | dm_sync[1];
      // Reset signalling is SE0, driven only from the root port
      assign host_data_plus_line_o[gi] = 1'b0;
      assign host_data_minus_line_o[gi] = 1'b0;
      assign host_data_line_oe_o[gi] = port_reset_i[gi];
      // With protection on, an unrecoverable error cuts power to every port
      assign port_power_o[gi] = port_power_en_i[gi] &
        ~(overcurrent_protect_en_i & unrecoverable_error_o);
      always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          dp_sync <= 2'h0;
          dm_sync <= 2'h0;
          deb <= 16'h0000;
          line_prev <= 1'b0;
          port_connect_o[gi] <= 1'b0;
          port_low_speed_o[gi] <= 1'b0;
          port_connect_change_o[gi] <= 1'b0;
        end else begin
          dp_sync <= {dp_sync[0], host_data_plus_line_i[gi]};
          dm_sync <= {dm_sync[0], host_data_minus_line_i[gi]};
          line_prev <= attached;
          port_connect_change_o[gi] <= 1'b0;
          // Debounce: level must hold before status changes
          if (port_reset_i[gi] || (attached != line_prev) ||
              (attached == port_connect_o[gi])) begin
            deb <= 16'h0000;
          end else if (deb == DEB_CYCLES[15:0] - 16'h0001) begin
            deb <= 16'h0000;
            port_connect_o[gi] <= attached;
            port_low_speed_o[gi] <= dm_sync[1] & ~dp_sync[1];
            port_connect_change_o[gi] <= 1'b1;
          end else begin
            deb <= deb + 16'h0001;
          end
        end
      end
    end
  endgenerate
endmodule // usb_host_list_engine
`default_nettype wire

// ### usb_host_regs.vh
`ifndef USB_HOST_REGS_VH
`define USB_HOST_REGS_VH
// Descriptor dword offsets, in bytes
`define ED_CTRL_OFS      32'h0000_0000
`define ED_TAIL_OFS      32'h0000_0004
`define ED_HEAD_OFS      32'h0000_0008
`define ED_NEXT_OFS      32'h0000_000c
`define TD_CTRL_OFS      32'h0000_0000
`define TD_CBP_OFS       32'h0000_0004
`define TD_NEXT_OFS      32'h0000_0008
`define TD_BE_OFS        32'h0000_000c
// Shared communication area: done queue head slot
`define HCCA_DONE_OFS    32'h0000_0084
// Index of the last dword in each descriptor
`define ED_DWORDS        3'h3
`define TD_DWORDS        3'h3
// Field positions
`define ED_SKIP_BIT      14
`define ED_HALT_BIT      0
`define TD_DP_HI         20
`define TD_DP_LO         19
`define TD_DP_IN         2'h2
`define TD_CC_NOERROR    4'h0
// Alignment masks
`define DESC_ALIGN_MASK  32'h0000_000f
`define HCCA_ALIGN_MASK  32'h0000_00ff
`define WORD_ALIGN_MASK  32'h0000_0003
// Attach debounce time and its cycle count at 40 MHz
`define CLOCK_MHZ        40
`define ATTACH_DEBOUNCE_NS 2500
`define ATTACH_DEBOUNCE_CYCLES ((`ATTACH_DEBOUNCE_NS * `CLOCK_MHZ + 999) / 1000)
// Default number of downstream ports
`define ROOT_PORTS       2
`endif

// ### desc_buffer.v
`timescale 1ns/1ps
`default_nettype none
// Holds the descriptor words most recently fetched; read data is registered
module desc_buffer #(
  parameter AW = 3,
  parameter DW = 32
) (
  input  wire          clock_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg  [DW-1:0] rd_data_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];  // Word storage, no reset needed

  // Write port and registered read port
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // desc_buffer
`default_nettype wire

// ### usb_host_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// System memory behind the master port; answers after lat_i wait cycles
module usb_host_mem_model (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  input  wire logic [3:0]  lat_i,      // Wait cycles before the answer
  input  wire logic [31:0] err_addr_i, // Access here ends in an abort
  output var  logic        mem_ack_o,
  output var  logic        mem_err_o,
  output var  logic [31:0] mem_rdata_o
);
  logic [31:0] mem [0:511];            // 2 KB of word storage
  logic [3:0]  cnt;                    // Cycles waited on this access
  // One access at a time; read data is junk outside the answer cycle
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_ack_o   <= 1'b0;
      mem_err_o   <= 1'b0;
      cnt         <= 4'h0;
      mem_rdata_o <= 32'h0;
    end else begin
      mem_rdata_o <= ~mem_rdata_o;     // Never leave a stale word lying
      if (mem_ack_o || mem_err_o) begin
        mem_ack_o <= 1'b0;
        mem_err_o <= 1'b0;
        cnt       <= 4'h0;
      end else if (mem_req_i) begin
        if (cnt != lat_i) begin
          cnt <= cnt + 4'h1;
        end else if (mem_addr_i == err_addr_i) begin
          mem_err_o <= 1'b1;
        end else begin
          mem_ack_o <= 1'b1;
          if (mem_we_i) begin
            mem[mem_addr_i[10:2]] <= mem_wdata_i;
          end else begin
            mem_rdata_o <= mem[mem_addr_i[10:2]];
          end
        end
      end
    end
  end
endmodule // usb_host_mem_model
`default_nettype wire

// ### usb_host_list_engine_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_list_engine_monitor #(
  parameter NUM_PORTS = 2
) (
  input wire logic                 clock_i,
  input wire logic                 rst_b_i,
  input wire logic                 error_clear_i,
  input wire logic                 unrecoverable_error_o,
  input wire logic [7:0]           num_ports_o,
  input wire logic                 mem_req_o,
  input wire logic                 mem_we_o,
  input wire logic [31:0]          mem_addr_o,
  input wire logic                 mem_ack_i,
  input wire logic                 mem_err_i,
  input wire logic                 tx_valid_o,
  input wire logic                 tx_ready_i,
  input wire logic [31:0]          tx_data_o,
  input wire logic [NUM_PORTS-1:0] port_reset_i,
  input wire logic [NUM_PORTS-1:0] host_data_line_oe_o,
  input wire logic [NUM_PORTS-1:0] port_power_en_i,
  input wire logic                 overcurrent_protect_en_i,
  input wire logic [NUM_PORTS-1:0] port_power_o,
  input wire logic [NUM_PORTS-1:0] port_connect_change_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  chk_err_on_abort: assert property (mem_req_o && mem_err_i |=> unrecoverable_error_o)
    else $error("abort did not raise the error flag");
  chk_err_sticky: assert property (unrecoverable_error_o && !error_clear_i |=> unrecoverable_error_o)
    else $error("error flag dropped without clear");
  chk_req_holds: assert property (mem_req_o && !mem_ack_i && !mem_err_i
    |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("master request moved before its answer");
  chk_req_gap: assert property (mem_req_o && (mem_ack_i || mem_err_i) |=> !mem_req_o)
    else $error("no idle cycle between accesses");
  chk_word_align: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
    else $error("misaligned access issued");
  chk_port_count: assert property (num_ports_o == 8'(NUM_PORTS))
    else $error("port count wrong");
  chk_line_drive: assert property (host_data_line_oe_o == port_reset_i)
    else $error("line enable not from root port");
  chk_power_cut: assert property (port_power_o == (port_power_en_i &
    ~{NUM_PORTS{overcurrent_protect_en_i & unrecoverable_error_o}}))
    else $error("port power wrong");
  chk_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("outgoing word not held");
  chk_change_pulse: assert property (|port_connect_change_o |=> port_connect_change_o == '0)
    else $error("change pulse too long");
endmodule // usb_host_list_engine_monitor
bind usb_host_list_engine usb_host_list_engine_monitor #(.NUM_PORTS(NUM_PORTS)) mon_i (
  .clock_i, .rst_b_i, .error_clear_i, .unrecoverable_error_o, .num_ports_o, .mem_req_o,
  .mem_we_o, .mem_addr_o, .mem_ack_i, .mem_err_i, .tx_valid_o, .tx_ready_i, .tx_data_o,
  .port_reset_i, .host_data_line_oe_o, .port_power_en_i, .overcurrent_protect_en_i,
  .port_power_o, .port_connect_change_o);
`default_nettype wire

// ### usb_host_list_engine_test.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_list_engine_test;
  logic clock_i = 1'b0, rst_b_i = 1'b0, list_enable_i = 1'b0, error_clear_i = 1'b0;
  logic tx_ready_i = 1'b0, rx_valid_i = 1'b0, stall = 1'b0;   // Stall toggles ready
  logic overcurrent_protect_en_i = 1'b1;
  logic [31:0] hcca_base_i = 32'h400;                         // 256-byte aligned
  logic [31:0] list_head_i = 32'h0, rx_data_i = 32'h0;
  logic [31:0] err_addr = 32'hffff_fff0;                      // No abort by default
  logic [3:0] lat = 4'h0;
  logic [2:0] desc_rd_addr_i = 3'h0;
  logic [1:0] host_data_plus_line_i = 2'h0, host_data_minus_line_i = 2'h0;
  logic [1:0] port_reset_i = 2'h0, port_power_en_i = 2'h3;
  wire logic mem_req_o, mem_we_o, mem_ack_i, mem_err_i, tx_valid_o, rx_ready_o;
  wire logic unrecoverable_error_o;
  wire logic [7:0] num_ports_o;
  wire logic [31:0] done_head_o, mem_addr_o, mem_wdata_o, mem_rdata_i, tx_data_o;
  wire logic [31:0] desc_rd_data_o;
  wire logic [1:0] host_data_plus_line_o, host_data_minus_line_o, host_data_line_oe_o;
  wire logic [1:0] port_power_o, port_connect_o, port_low_speed_o, port_connect_change_o;
  int mismatches = 0, comparisons = 0, reqs = 0, chg = 0, rxn = 0;
  logic [31:0] txq [$];                                       // Words seen leaving
  usb_host_list_engine #(.NUM_PORTS(2), .DEB_CYCLES(4)) usb_host_list_engine_i (
    .clock_i, .rst_b_i, .list_enable_i, .hcca_base_i, .list_head_i, .error_clear_i,
    .unrecoverable_error_o, .num_ports_o, .done_head_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_ack_i, .mem_err_i, .mem_rdata_i, .tx_data_o, .tx_valid_o, .tx_ready_i,
    .rx_data_i, .rx_valid_i, .rx_ready_o, .desc_rd_addr_i, .desc_rd_data_o,
    .host_data_plus_line_i, .host_data_minus_line_i, .host_data_plus_line_o,
    .host_data_minus_line_o, .host_data_line_oe_o, .port_reset_i, .port_power_en_i,
    .overcurrent_protect_en_i, .port_power_o, .port_connect_o, .port_low_speed_o,
    .port_connect_change_o);
  usb_host_mem_model mm_i (.clock_i, .rst_b_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .lat_i(lat), .err_addr_i(err_addr),
    .mem_ack_o(mem_ack_i), .mem_err_o(mem_err_i), .mem_rdata_o(mem_rdata_i));
  always #12.5 clock_i = ~clock_i; // One 40 MHz clock stands in for the USB clock
  // Far side drain and traffic counters
  always @(posedge clock_i) begin
    tx_ready_i <= stall ? ~tx_ready_i : 1'b1;
    if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
    if (mem_req_o) reqs++;
    chg += $countones(port_connect_change_o);
    if (rx_ready_o) rxn++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mm_i.mem[a[10:2]];
  endfunction
  // Lay four dwords down at a descriptor address
  task automatic put4(input logic [31:0] a, input logic [31:0] d0, d1, d2, d3);
    mm_i.mem[a[10:2]] = d0;
    mm_i.mem[a[10:2]+1] = d1;
    mm_i.mem[a[10:2]+2] = d2;
    mm_i.mem[a[10:2]+3] = d3;
  endtask
  // Walk one list until the given descriptor retires, then stop
  task automatic walk(input logic [31:0] ed, input logic [31:0] td);
    int n;
    list_head_i <= ed;
    list_enable_i <= 1'b1;
    for (n = 0; n < 800 && done_head_o !== td; n++) @(posedge clock_i);
    cyc(40);
    list_enable_i <= 1'b0;
    cyc(2);
  endtask
  task automatic clr;
    list_enable_i <= 1'b0;
    error_clear_i <= 1'b1;
    cyc(1);
    error_clear_i <= 1'b0;
    cyc(2);
  endtask
  task automatic t_reset;
    chk("ports", 32'(num_ports_o), 32'h2);
    chk("error", 32'(unrecoverable_error_o), 32'h0);
    chk("done", done_head_o, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_out;
    put4(32'h100, 32'h0, 32'h240, 32'h200, 32'h0);
    put4(32'h200, 32'hf0e0_0000, 32'h300, 32'h240, 32'h304);
    put4(32'h300, 32'h3c3c_0001, 32'h3c3c_0002, 32'h0, 32'h0);
    lat <= 4'h2;
    stall <= 1'b1;
    walk(32'h100, 32'h200);
    stall <= 1'b0;
    chk("tx count", 32'(txq.size()), 32'h2);
    chk("tx word0", txq[0], 32'h3c3c_0001);
    chk("tx word1", txq[1], 32'h3c3c_0002);
    chk("td status", rd(32'h200), 32'h00e0_0000);
    chk("td buffer", rd(32'h204), 32'h0);
    chk("td link", rd(32'h208), 32'h0);
    chk("ed head", rd(32'h108), 32'h240);
    chk("hcca done", rd(32'h484), 32'h200);
    chk("done", done_head_o, 32'h200);
    desc_rd_addr_i <= 3'h5;
    cyc(3);
    chk("desc word", desc_rd_data_o, 32'h300);
    $display("test out done");
  endtask
  task automatic t_in;
    put4(32'h140, 32'h0, 32'h2c0, 32'h280, 32'h0);
    put4(32'h280, 32'hf010_0000, 32'h380, 32'h2c0, 32'h380);
    rx_data_i <= 32'h5a5a_1234;
    rx_valid_i <= 1'b1;
    lat <= 4'h0;
    walk(32'h140, 32'h280);
    rx_valid_i <= 1'b0;
    chk("rx stored", rd(32'h380), 32'h5a5a_1234);
    chk("td status", rd(32'h280), 32'h0010_0000);
    chk("td link", rd(32'h288), 32'h200);
    chk("hcca done", rd(32'h484), 32'h280);
    chk("rx taken", 32'(rxn), 32'h1);
    $display("test in done");
  endtask
  // Skipped endpoint passes on; a zero-length transfer moves no data
  task automatic t_skip;
    put4(32'h1e0, 32'h0000_4000, 32'h3c0, 32'h3a0, 32'h1f0);
    put4(32'h1f0, 32'h0, 32'h3c0, 32'h3b0, 32'h0);
    put4(32'h3b0, 32'hf0a0_0000, 32'h0, 32'h3c0, 32'h0);
    walk(32'h1e0, 32'h3b0);
    chk("skip head", rd(32'h1e8), 32'h3a0);
    chk("ed head", rd(32'h1f8), 32'h3c0);
    chk("td status", rd(32'h3b0), 32'h00a0_0000);
    chk("td link", rd(32'h3b8), 32'h280);
    chk("tx count", 32'(txq.size()), 32'h2);
    chk("done", done_head_o, 32'h3b0);
    $display("test skip done");
  endtask
  task automatic t_abort;
    int n;
    err_addr <= 32'h180;
    list_head_i <= 32'h180;
    list_enable_i <= 1'b1;
    for (n = 0; n < 100 && unrecoverable_error_o !== 1'b1; n++) @(posedge clock_i);
    cyc(1);
    chk("error", 32'(unrecoverable_error_o), 32'h1);
    chk("power", 32'(port_power_o), 32'h0);
    err_addr <= 32'hffff_fff0;
    clr();
    chk("error", 32'(unrecoverable_error_o), 32'h0);
    chk("power", 32'(port_power_o), 32'h3);
    $display("test abort done");
  endtask
  task automatic t_align;
    int r;
    r = reqs;
    list_head_i <= 32'h1c4;
    list_enable_i <= 1'b1;
    cyc(20);
    chk("error", 32'(unrecoverable_error_o), 32'h1);
    chk("accesses", 32'(reqs - r), 32'h0);
    clr();
    $display("test align done");
  endtask
  task automatic t_attach;
    port_reset_i <= 2'h2;
    host_data_minus_line_i <= 2'h1;
    host_data_plus_line_i <= 2'h2;
    cyc(20);
    chk("connect", 32'(port_connect_o), 32'h1);
    chk("line enable", 32'(host_data_line_oe_o), 32'h2);
    chk("line drive", 32'({host_data_plus_line_o, host_data_minus_line_o}), 32'h0);
    port_reset_i <= 2'h0;
    cyc(20);
    chk("connect", 32'(port_connect_o), 32'h3);
    chk("low speed", 32'(port_low_speed_o), 32'h1);
    chk("changes", 32'(chg), 32'h2);
    $display("test attach done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    cyc(20000);
    mismatches++;
    final_report();
  end
  initial begin
    cyc(4);
    rst_b_i <= 1'b1; // No interrupt line to route beforehand
    cyc(2);
    t_reset();
    t_out();
    t_in();
    t_skip();
    t_abort();
    t_align();
    t_attach();
    final_report();
  end
endmodule // usb_host_list_engine_test
`default_nettype wire
